// ### hw/isv_cfg.svh
`ifndef ISV_CFG_SVH
`define ISV_CFG_SVH

// Special-register numbers
`define ISV_SPR_NC_RADDR   10'h01A
`define ISV_SPR_NC_STATE   10'h01B
`define ISV_SPR_VEC_BASE   10'h3D6
`define ISV_SPR_CR_RADDR   10'h3DE
`define ISV_SPR_CR_STATE   10'h3DF

// Machine-state bit positions (bit 0 is the msb)
`define ISV_MS_WE    (31 - 13)
`define ISV_MS_CE    (31 - 14)
`define ISV_MS_EE    (31 - 16)
`define ISV_MS_PR    (31 - 17)
`define ISV_MS_ME    (31 - 19)
`define ISV_MS_DWE   (31 - 21)
`define ISV_MS_DE    (31 - 22)

// Kept on entry: none for machine check, ME for other critical,
// CE ME DE for noncritical
`define ISV_KEEP_NONE  32'h0000_0000
`define ISV_KEEP_ANY   32'h0000_1000
`define ISV_KEEP_NOTME 32'h0002_1200

// Field layouts
`define ISV_WORD_ALIGN 32'hFFFF_FFFC
`define ISV_PFX_HI     31
`define ISV_PFX_LO     16

// Reset values
`define ISV_RST_WORD   32'h0000_0000

`endif

// ### hw/isv_pkg.sv
package isv_pkg;

  // Interrupt classes presented by the pipeline
  typedef enum logic [2:0]
  {
    ISV_CLS_NONCRIT  = 3'h0,
    ISV_CLS_CRIT_IN  = 3'h1,
    ISV_CLS_MCHK     = 3'h2,
    ISV_CLS_WDOG     = 3'h3,
    ISV_CLS_DEBUG    = 3'h4,
    ISV_CLS_EXT      = 3'h5,
    ISV_CLS_TIMER    = 3'h6
  } isv_cls_t;

  // Sequencer states
  typedef enum logic [2:0]
  {
    ISV_ST_RUN    = 3'b001,
    ISV_ST_NCRET  = 3'b010,
    ISV_ST_CRRET  = 3'b100
  } isv_state_t;

endpackage : isv_pkg

// ### hw/isv_unit.sv
`timescale 1ns/1ps
`include "isv_cfg.svh"

// Notes on behaviour
// - Noncritical entry saves interrupted address, low two bits forced zero.
// - Pipeline picks faulting or next address; system call saves next.
// - Noncritical entry copies whole machine state into noncritical save.
// - Noncritical return jumps to saved address, reloads full machine state.
// - Critical input, machine check, watchdog, debug use the critical pair.
// - Critical entry saves interrupted address, low two bits zero.
// - Watchdog entry saves next sequential address as critical return.
// - Critical entry copies machine state into critical save register.
// - Every entry clears wait enable and debug wait enable.
// - Every entry clears external enable and user state.
// - Every entry clears both translation bits, real mode.
// - Every entry clears unsupported and reserved machine-state bits.
// - Only critical entries clear critical-input and debug enables.
// - Only machine-check entry clears machine-check enable.
// - Handler address is vector prefix above the 16-bit offset.
// - Low 16 bits of vector base are ignored, 64KB aligned.
// - Noncritical pair are privileged special registers 26 and 27.
// - Critical pair are privileged special registers 990 and 991.
// - Vector base is privileged special register 982.
// - External and timer entries only taken while external enable set.
module isv_unit
  import isv_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Interrupt request from the pipeline
  input  wire logic        int_req,
  input  wire isv_cls_t    int_cls,
  input  wire logic [31:0] int_cur_addr,
  input  wire logic [31:0] int_next_addr,
  input  wire logic        int_use_next,
  input  wire logic [15:0] int_vec_offset,
  // Return instructions
  input  wire logic        rfi_req,
  input  wire logic        rfci_req,
  // Machine-state write from the pipeline
  input  wire logic        ms_wr,
  input  wire logic [31:0] ms_wdata,
  // Special-register move port
  input  wire logic        spr_wr,
  input  wire logic        spr_rd,
  input  wire logic [9:0]  spr_num,
  input  wire logic [31:0] spr_wdata,
  // Outputs
  output logic [31:0]      spr_rdata,
  output logic             spr_hit,
  output logic             spr_priv_err,
  output logic             int_taken,
  output logic             redirect,
  output logic [31:0]      redirect_addr,
  output logic [31:0]      machine_state_reg
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] noncrit_return_addr;
  logic [31:0] noncrit_saved_state;
  logic [31:0] vector_base_reg;
  logic [31:0] crit_return_addr;
  logic [31:0] crit_saved_state;
  isv_state_t  state;
  isv_state_t  next_state;

  // ****************************************************************
  // Entry decode
  // ****************************************************************
  wire logic        is_crit;
  wire logic        is_mchk;
  wire logic        is_masked_cls;
  wire logic        take;
  wire logic [31:0] entry_addr;
  wire logic [31:0] keep_mask;
  wire logic [31:0] entry_state;
  wire logic [15:0] vector_base_prefix;
  wire logic [31:0] handler_addr;
  wire logic        priv_ok;
  wire logic        sel_nc_ra;
  wire logic        sel_nc_st;
  wire logic        sel_vb;
  wire logic        sel_cr_ra;
  wire logic        sel_cr_st;
  wire logic        any_sel;
  wire logic        do_wr;
  wire logic [31:0] rd_mux;

  // Load enables and next values
  wire logic        take_nc;
  wire logic        take_cr;
  wire logic        in_ncret;
  wire logic        in_crret;
  wire logic        ld_nc_ra;
  wire logic        ld_nc_st;
  wire logic        ld_vb;
  wire logic        ld_cr_ra;
  wire logic        ld_cr_st;
  wire logic        ld_ms;
  wire logic        ld_redirect_addr;
  wire logic [31:0] next_noncrit_return_addr;
  wire logic [31:0] next_noncrit_saved_state;
  wire logic [31:0] next_crit_return_addr;
  wire logic [31:0] next_crit_saved_state;
  wire logic [31:0] next_machine_state;
  wire logic [31:0] next_redirect_addr;
  wire logic        next_redirect;
  wire logic [31:0] next_spr_rdata;
  wire logic        spr_access;
  wire logic        next_spr_hit;
  wire logic        next_spr_priv_err;

  // Critical classes use the second save pair
  assign is_crit = (int_cls == ISV_CLS_CRIT_IN) ||
                   (int_cls == ISV_CLS_MCHK) ||
                   (int_cls == ISV_CLS_WDOG) ||
                   (int_cls == ISV_CLS_DEBUG);
  assign is_mchk = (int_cls == ISV_CLS_MCHK);
  // External and timer classes obey the external enable
  assign is_masked_cls = (int_cls == ISV_CLS_EXT) ||
                         (int_cls == ISV_CLS_TIMER);
  // Masked requests stay pending at the source
  assign take = int_req && (state == ISV_ST_RUN) &&
                !(is_masked_cls &&
                  !machine_state_reg[`ISV_MS_EE]);

  // Next address for watchdog and system call, else pipeline choice
  assign entry_addr = ((int_use_next || int_cls == ISV_CLS_WDOG) ?
                       int_next_addr : int_cur_addr)
                      & `ISV_WORD_ALIGN;

  // Only CE, ME, DE may survive entry; all else clears
  assign keep_mask = is_crit ? (is_mchk ? `ISV_KEEP_NONE :
                                `ISV_KEEP_ANY) :
                     `ISV_KEEP_NOTME;
  assign entry_state = machine_state_reg & keep_mask;

  // Handler table on a 64KB boundary
  assign vector_base_prefix = vector_base_reg[`ISV_PFX_HI:`ISV_PFX_LO];
  assign handler_addr = {vector_base_prefix, int_vec_offset};

  // ****************************************************************
  // Special-register decode
  // ****************************************************************
  // Moves need privileged state
  assign priv_ok   = !machine_state_reg[`ISV_MS_PR];
  assign sel_nc_ra = (spr_num == `ISV_SPR_NC_RADDR);
  assign sel_nc_st = (spr_num == `ISV_SPR_NC_STATE);
  assign sel_vb    = (spr_num == `ISV_SPR_VEC_BASE);
  assign sel_cr_ra = (spr_num == `ISV_SPR_CR_RADDR);
  assign sel_cr_st = (spr_num == `ISV_SPR_CR_STATE);
  assign any_sel   = sel_nc_ra | sel_nc_st | sel_vb | sel_cr_ra | sel_cr_st;
  // Hardware entry wins over a same-cycle software write
  assign do_wr     = spr_wr && priv_ok && !take;
  assign rd_mux    = sel_nc_ra ? noncrit_return_addr :
                     sel_nc_st ? noncrit_saved_state :
                     sel_vb    ? vector_base_reg :
                     sel_cr_ra ? crit_return_addr :
                     sel_cr_st ? crit_saved_state : `ISV_RST_WORD;

  // ****************************************************************
  // Load enables and next values
  // ****************************************************************
  assign take_nc  = take && !is_crit;
  assign take_cr  = take && is_crit;
  assign in_ncret = (state == ISV_ST_NCRET);
  assign in_crret = (state == ISV_ST_CRRET);

  // Entry saves win over a same-cycle software move
  assign ld_nc_ra = take_nc || (do_wr && sel_nc_ra);
  assign ld_nc_st = take_nc || (do_wr && sel_nc_st);
  assign ld_vb    = do_wr && sel_vb;
  assign ld_cr_ra = take_cr || (do_wr && sel_cr_ra);
  assign ld_cr_st = take_cr || (do_wr && sel_cr_st);

  assign next_noncrit_return_addr = take_nc ? entry_addr
                                            : spr_wdata;
  assign next_noncrit_saved_state = take_nc ? machine_state_reg
                                            : spr_wdata;
  assign next_crit_return_addr    = take_cr ? entry_addr
                                            : spr_wdata;
  assign next_crit_saved_state    = take_cr ? machine_state_reg
                                            : spr_wdata;

  // Entry first, then a pending return, then a pipeline write
  assign ld_ms              = take || in_ncret || in_crret || ms_wr;
  assign next_machine_state = take     ? entry_state :
                              in_ncret ? noncrit_saved_state :
                              in_crret ? crit_saved_state :
                                         ms_wdata;
  assign ld_redirect_addr   = take || in_ncret || in_crret;
  assign next_redirect_addr = take     ? handler_addr :
                              in_ncret ? noncrit_return_addr :
                                         crit_return_addr;
  assign next_redirect      = take || (state != ISV_ST_RUN);

  // Read data is zero unless a privileged read hits
  assign spr_access        = spr_rd || spr_wr;
  assign next_spr_rdata    = (spr_rd && priv_ok) ? rd_mux : `ISV_RST_WORD;
  assign next_spr_hit      = spr_access && any_sel && priv_ok;
  assign next_spr_priv_err = spr_access && any_sel && !priv_ok;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // A return pulse beside an entry in one cycle is dropped
  always_comb
  begin
    next_state = state;
    case (state)
      ISV_ST_RUN:
      begin
        if (!take && rfi_req)
          next_state = ISV_ST_NCRET;
        else if (!take && rfci_req)
          next_state = ISV_ST_CRRET;
      end
      ISV_ST_NCRET: next_state = ISV_ST_RUN;
      ISV_ST_CRRET: next_state = ISV_ST_RUN;
      default:      next_state = ISV_ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ISV_ST_RUN; // Return idles one cycle before the restore
    else
      state <= next_state;
  end

  // ****************************************************************
  // Save pairs and vector base
  // ****************************************************************
  // Save registers load from entry or from a move; vector base only from a move
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      noncrit_return_addr <= `ISV_RST_WORD;
    else if (ld_nc_ra)
      noncrit_return_addr <= next_noncrit_return_addr;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      noncrit_saved_state <= `ISV_RST_WORD;
    else if (ld_nc_st)
      noncrit_saved_state <= next_noncrit_saved_state;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      vector_base_reg <= `ISV_RST_WORD;
    else if (ld_vb)
      vector_base_reg <= spr_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crit_return_addr <= `ISV_RST_WORD;
    else if (ld_cr_ra)
      crit_return_addr <= next_crit_return_addr;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crit_saved_state <= `ISV_RST_WORD;
    else if (ld_cr_st)
      crit_saved_state <= next_crit_saved_state;
  end

  // ****************************************************************
  // Machine state and redirect
  // ****************************************************************
  // Redirect and entry pulse last one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      machine_state_reg <= `ISV_RST_WORD;
    else if (ld_ms)
      machine_state_reg <= next_machine_state;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      redirect_addr <= `ISV_RST_WORD;
    else if (ld_redirect_addr)
      redirect_addr <= next_redirect_addr;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      redirect <= 1'b0;
    else
      redirect <= next_redirect;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      int_taken <= 1'b0;
    else
      int_taken <= take;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Result pulses follow the move by one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      spr_rdata <= `ISV_RST_WORD;
    else
      spr_rdata <= next_spr_rdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      spr_hit <= 1'b0;
    else
      spr_hit <= next_spr_hit;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      spr_priv_err <= 1'b0;
    else
      spr_priv_err <= next_spr_priv_err;
  end

endmodule : isv_unit

// ### tb/isv_pipe_model.sv
`timescale 1ns/1ps
// ****
// Pipeline side: next sequential address
// ****
module isv_pipe_model
(
  // Addresses
  input  wire logic [31:0] cur_addr,
  output logic      [31:0] next_addr
);
  assign next_addr = cur_addr + 32'h0000_0004;
endmodule : isv_pipe_model

// ### tb/isv_unit_assertions.sv
`timescale 1ns/1ps
// ****
// Entry and return checks
// ****
module isv_unit_assertions
  import isv_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Requests
  input wire logic        int_req,
  input wire isv_cls_t    int_cls,
  input wire logic [15:0] int_vec_offset,
  input wire logic        rfi_req,
  input wire logic        rfci_req,
  input wire logic        spr_rd,
  input wire logic [9:0]  spr_num,
  // Results
  input wire logic        spr_hit,
  input wire logic        spr_priv_err,
  input wire logic        int_taken,
  input wire logic        redirect,
  input wire logic [31:0] redirect_addr,
  input wire logic [31:0] machine_state_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        ret_any, me, mapped;
  logic [31:0] ms;
  assign ms = machine_state_reg;
  assign me = ms[12];
  assign ret_any = rfi_req | rfci_req;
  assign mapped = spr_num inside {10'h01A, 10'h01B, 10'h3D6, 10'h3DE, 10'h3DF};
  a_entry_jump: assert property (int_taken |-> redirect &&
    redirect_addr[15:0] == $past(int_vec_offset)) else $error("bad jump");
  a_entry_clear: assert property (int_taken |->
    (ms & 32'hFFFD_EDFF) == 32'h0) else $error("state not cleared");
  a_crit_mask: assert property (int_taken && $past(int_cls) inside
    {ISV_CLS_CRIT_IN, ISV_CLS_MCHK, ISV_CLS_WDOG, ISV_CLS_DEBUG} |->
    (ms & 32'h0002_0200) == 32'h0) else $error("critical enables kept");
  a_nc_keep: assert property (int_taken && $past(int_cls) == ISV_CLS_NONCRIT
    |-> (ms & 32'h0002_0200) == ($past(ms) & 32'h0002_0200))
    else $error("enables lost");
  a_me_keep: assert property (int_taken |-> me ==
    ($past(int_cls) != ISV_CLS_MCHK && $past(me))) else $error("bad check enable");
  a_ext_mask: assert property (int_req && !ms[15] && int_cls inside
    {ISV_CLS_EXT, ISV_CLS_TIMER} |=> !int_taken) else $error("masked taken");
  a_ret_time: assert property (ret_any && !int_req && !$past(ret_any)
    && !$past(ret_any, 2) |-> ##2 redirect) else $error("return late");
  a_spr_priv: assert property (spr_rd && mapped && ms[14]
    |=> spr_priv_err && !spr_hit) else $error("user access");
  a_spr_hit: assert property (spr_rd && mapped && !ms[14]
    |=> spr_hit) else $error("no hit");
endmodule : isv_unit_assertions

bind isv_unit isv_unit_assertions i_chk (.clk(clk), .rst_n(rst_n),
  .int_req(int_req), .int_cls(int_cls), .int_vec_offset(int_vec_offset),
  .rfi_req(rfi_req), .rfci_req(rfci_req), .spr_rd(spr_rd),
  .spr_num(spr_num), .spr_hit(spr_hit), .spr_priv_err(spr_priv_err),
  .int_taken(int_taken), .redirect(redirect),
  .redirect_addr(redirect_addr), .machine_state_reg(machine_state_reg));

// ### tb/interrupt_state_save_and_vectoring_tb.sv
`timescale 1ns/1ps
// ****
// Entry, save and return bench
// ****
module interrupt_state_save_and_vectoring_tb;
  import isv_pkg::*;
  logic        clk, rst_n, int_req, int_use_next, rfi_req, rfci_req, ms_wr;
  logic        spr_wr, spr_rd, spr_hit, spr_priv_err, int_taken, redirect;
  logic        crit, nx;
  isv_cls_t    int_cls, c;
  logic [31:0] int_cur_addr, int_next_addr, ms_wdata, spr_wdata, spr_rdata;
  logic [31:0] redirect_addr, machine_state_reg, vb, old, a, ra;
  logic [15:0] int_vec_offset;
  logic [9:0]  spr_num;
  logic [9:0]  save_num [4] = '{10'h01A, 10'h01B, 10'h3DE, 10'h3DF};
  int          bad_count, n_checks;
  isv_unit i_dut (.clk(clk), .rst_n(rst_n), .int_req(int_req),
    .int_cls(int_cls), .int_cur_addr(int_cur_addr),
    .int_next_addr(int_next_addr), .int_use_next(int_use_next),
    .int_vec_offset(int_vec_offset), .rfi_req(rfi_req), .rfci_req(rfci_req),
    .ms_wr(ms_wr), .ms_wdata(ms_wdata), .spr_wr(spr_wr), .spr_rd(spr_rd),
    .spr_num(spr_num), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata),
    .spr_hit(spr_hit), .spr_priv_err(spr_priv_err), .int_taken(int_taken),
    .redirect(redirect), .redirect_addr(redirect_addr),
    .machine_state_reg(machine_state_reg));
  isv_pipe_model i_pipe (.cur_addr(int_cur_addr), .next_addr(int_next_addr));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic special_register(input logic wr, input logic [9:0] n, input logic [31:0] d);
    @(posedge clk);
    spr_wr <= wr;
    spr_rd <= !wr;
    spr_num <= n;
    spr_wdata <= d;
    @(posedge clk);
    spr_wr <= 1'b0;
    spr_rd <= 1'b0;
    #1;
  endtask : special_register
  task automatic set_ms(input logic [31:0] v);
    @(posedge clk);
    ms_wr <= 1'b1;
    ms_wdata <= v;
    @(posedge clk);
    ms_wr <= 1'b0;
  endtask : set_ms
  task automatic enter(input isv_cls_t k, input logic [31:0] ad, input logic n);
    @(posedge clk);
    int_req <= 1'b1;
    int_cls <= k;
    int_cur_addr <= ad;
    int_use_next <= n;
    int_vec_offset <= 16'($urandom);
    @(posedge clk);
    int_req <= 1'b0;
    #1;
  endtask : enter
  task automatic ret(input logic cr);
    @(posedge clk);
    rfi_req <= !cr;
    rfci_req <= cr;
    @(posedge clk);
    rfi_req <= 1'b0;
    rfci_req <= 1'b0;
    @(posedge clk);
    #1;
  endtask : ret
  // Bits that survive entry, by class
  function automatic logic [31:0] keep(input isv_cls_t k, input logic cr);
    return k == ISV_CLS_MCHK ? 32'h0 : cr ? 32'h0000_1000 : 32'h0002_1200;
  endfunction : keep
  initial
  begin
    {int_req, int_use_next, rfi_req, rfci_req, ms_wr, spr_wr, spr_rd} = '0;
    {int_cur_addr, ms_wdata, spr_wdata, int_vec_offset, spr_num} = '0;
    int_cls = ISV_CLS_NONCRIT;
    rst_n = 1'b0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'h268A01A0));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 21; i++)
    begin
      c = isv_cls_t'(i % 7);
      crit = c inside {ISV_CLS_CRIT_IN, ISV_CLS_MCHK, ISV_CLS_WDOG, ISV_CLS_DEBUG};
      vb = $urandom;
      special_register(1'b1, 10'h3D6, vb);
      old = $urandom & 32'hFFFF_BFFF;
      if (c inside {ISV_CLS_EXT, ISV_CLS_TIMER})
      begin
        set_ms(old & 32'hFFFF_7FFF);
        enter(c, $urandom, 1'b0);
        chk(int_taken, 1'b0);
        chk(machine_state_reg, old & 32'hFFFF_7FFF);
        old = old | 32'h0000_8000;
      end
      set_ms(old);
      a = $urandom;
      nx = 1'($urandom);
      enter(c, a, nx);
      chk({int_taken, redirect}, 2'b11);
      chk(redirect_addr, {vb[31:16], int_vec_offset});
      chk(machine_state_reg, old & keep(c, crit));
      ra = ((nx || c == ISV_CLS_WDOG) ? a + 32'h4 : a) & 32'hFFFF_FFFC;
      special_register(1'b0, crit ? 10'h3DE : 10'h01A, 32'h0);
      chk(spr_rdata, ra);
      special_register(1'b0, crit ? 10'h3DF : 10'h01B, 32'h0);
      chk(spr_rdata, old);
      ret(crit);
      chk(redirect_addr, ra);
      chk(machine_state_reg, old);
      chk(redirect, 1'b1);
    end
    for (int i = 0; i < 4; i++)
    begin
      a = $urandom;
      special_register(1'b1, save_num[i], a);
      special_register(1'b0, save_num[i], 32'h0);
      chk(spr_rdata, a);
      if (i == 0)
        ra = a;
    end
    set_ms(32'h0000_4000);
    special_register(1'b0, 10'h3D6, 32'h0);
    chk({spr_priv_err, spr_hit}, 2'b10);
    special_register(1'b1, 10'h01A, ~ra);
    chk({spr_priv_err, spr_hit}, 2'b10);
    set_ms(32'h0);
    special_register(1'b0, 10'h3D6, 32'h0);
    chk(spr_rdata[31:16], vb[31:16]);
    special_register(1'b0, 10'h01A, 32'h0);
    chk(spr_rdata, ra);
    special_register(1'b0, 10'h155, 32'h0);
    chk({spr_hit, spr_rdata[15:0]}, 17'h0);
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule : interrupt_state_save_and_vectoring_tb
